// File: include/tbs_pkg.sv
// Shared constants of the token-bus event and command status block
package tbs_pkg;
  // Byte offsets inside the shared 256-byte table
  localparam logic [7:0]  TBL_REPLY_DEST_LO = 8'h86;
  localparam logic [7:0]  TBL_RESP_PTR      = 8'h88;
  localparam logic [7:0]  TBL_RWR_PTR       = 8'h8c;
  localparam logic [7:0]  TBL_CMD_AREA      = 8'h90;
  localparam logic [7:0]  TBL_RET_AREA      = 8'h96;
  localparam logic [7:0]  TBL_CMD_STATUS    = 8'h9c;
  localparam logic [7:0]  TBL_INT_STATUS0   = 8'ha8;
  localparam logic [7:0]  TBL_INT_MASK0     = 8'haa;
  localparam logic [7:0]  TBL_DUMP          = 8'he0;
  localparam logic [7:0]  DUMP_STRIDE       = 8'h06;
  localparam int          TBL_WORDS         = 128;
  localparam int          DMA_CHANNELS      = 4;
  // Command codes on the link
  localparam logic [3:0]  CMD_RESET         = 4'h0;
  localparam logic [3:0]  CMD_LOAD_FC       = 4'h1;
  localparam logic [3:0]  CMD_CLEAR_INT     = 4'h2;
  localparam logic [3:0]  CMD_RESP_READY    = 4'h3;
  localparam logic [3:0]  CMD_SET_ONE       = 4'h4;
  localparam logic [3:0]  CMD_SET_TWO       = 4'h5;
  localparam logic [3:0]  CMD_READ_VALUE    = 4'h6;
  // Command status word and status word 0 layout
  localparam logic [15:0] DONE_MASK         = 16'h8000;
  localparam logic [15:0] STATUS_RESET      = 16'h0000;
  localparam int          BIT_DONE          = 15;
  localparam int          BIT_BUS_ADDRESS_ERROR_FLAG         = 9;
  // Software register map of the host end
  localparam logic [11:0] APB_TABLE_LAST    = 12'h1fc;
  localparam logic [11:0] APB_CMD           = 12'h200;
  localparam logic [11:0] APB_STAT          = 12'h204;
  localparam int          STAT_BUSY         = 0;
  localparam int          STAT_IRQ          = 1;
  localparam int          STAT_DONE         = 2;
endpackage

// File: include/tbs_link_if.sv
// Link between the controller end and the host end: table port, command port, interrupt
`timescale 1ns/1ps
`default_nettype none
interface tbs_link_if;
  logic        mem_req;
  logic        mem_we;
  logic [7:0]  mem_addr;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;
  logic        mem_ack;
  logic        cmd_valid;
  logic [3:0]  cmd_code;
  logic        cmd_ack;
  logic        irq;
  modport device (output mem_req, mem_we, mem_addr, mem_wdata, cmd_ack, irq,
                  input  mem_rdata, mem_ack, cmd_valid, cmd_code);
  modport host   (input  mem_req, mem_we, mem_addr, mem_wdata, cmd_ack, irq,
                  output mem_rdata, mem_ack, cmd_valid, cmd_code);
endinterface
`default_nettype wire

// File: verilog/tbs_device.sv
// Controller end: event status, command results, reply pointers, error dump
//
// Functional notes
// - Predefined mode: use response pointer for reply
// - Otherwise pointer valid only after response-ready
// - Write received request descriptor address to table
// - Command area: opcode word plus two value words
// - Result area: two value words, opcode word, status word
// - Done bit after commands but reset, load-fc
// - Read-modify-write status; skip if already set
// - Always set bit; interrupt only when unmasked
// - Status stays until clear-interrupt command
// - Command-complete flag except reset, load-fc, clear
// - Pool-empty flags; last buffer descriptor withheld
// - Empty buffer pool still takes frame header
// - Transmit-queue-empty after last confirm flag
// - Token-skipped on skip address ordering
// - Token passed: save rotation time, restart
// - Bus or address error during own DMA
// - On error halt, pass token or seek successor, dump pointers
// - Host repairs before clearing bus error
// - Second error or error while offline: severe state
// - Pool-low flags on warning-marked descriptors
// - Overrun and underrun flags, abort on underrun
// - Request and response transmitted flags
`timescale 1ns/1ps
`default_nettype none
module tbs_device
  import tbs_pkg::*;
(
  input  wire logic                        clk_sys_i,
  input  wire logic                        resetn_i,
  tbs_link_if.device                       link,
  input  wire logic                        predefined_mode_i,
  input  wire logic                        rwr_rx_i,
  input  wire logic [31:0]                 rwr_fd_addr_i,
  input  wire logic                        fd_consumed_i,
  input  wire logic                        fd_last_i,
  input  wire logic                        fd_access_i,
  input  wire logic                        frame_pool_warning_bit_i,
  input  wire logic                        fd_avail_i,
  input  wire logic                        bd_access_i,
  input  wire logic                        bd_last_i,
  input  wire logic                        buffer_pool_warning_bit_i,
  input  wire logic                        bd_refill_i,
  input  wire logic                        confirm_set_i,
  input  wire logic                        confirm_last_i,
  input  wire logic                        token_heard_i,
  input  wire logic [15:0]                 token_sa_i,
  input  wire logic [15:0]                 token_da_i,
  input  wire logic [15:0]                 own_station_address_i,
  input  wire logic                        token_passed_i,
  input  wire logic                        dma_active_i,
  input  wire logic                        bus_master_i,
  input  wire logic [2:0]                  bus_error_code_inputs_i,
  input  wire logic                        chip_select_i,
  input  wire logic                        iack_i,
  input  wire logic                        has_token_i,
  input  wire logic                        has_successor_i,
  input  wire logic                        offline_i,
  input  wire logic [DMA_CHANNELS-1:0][2:0]  dma_fc_i,
  input  wire logic [DMA_CHANNELS-1:0][31:0] dma_ptr_i,
  input  wire logic                        fifo_wr_i,
  input  wire logic                        fifo_full_i,
  input  wire logic                        fifo_rd_i,
  input  wire logic                        fifo_empty_i,
  input  wire logic                        req_done_i,
  input  wire logic                        resp_done_i,
  input  wire logic [2:0]                  misc_event_i,
  output logic                             bd_grant_o,
  output logic                             rx_header_only_o,
  output logic                             abort_o,
  output logic                             halt_o,
  output logic                             pass_token_o,
  output logic                             seek_successor_o,
  output logic                             severe_o,
  output logic                             reply_fd_valid_o,
  output logic [31:0]                      reply_fd_addr_o,
  output logic [31:0]                      last_rotation_o
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_EV_RD = 4'h1, ST_EV_MK = 4'h3, ST_EV_WR = 4'h2,
    ST_CLR_WR = 4'h6, ST_CMD_RD = 4'h4, ST_CMD_RET = 4'h5, ST_CMD_STS = 4'h7,
    ST_RWR_WR = 4'hc, ST_RSP_RD = 4'hd, ST_DUMP = 4'hf
  } tbs_state_t;

  tbs_state_t state, next_state, cmd_route;
  logic [1:0]  w, next_w, ch, next_ch;
  logic [15:0] shadow, mask_q, mask_rd, rd_word, pending, snap, rsp_hi;
  logic [15:0] cw [3];
  logic [31:0] param [4];
  logic [31:0] rwr_addr, rot_cnt;
  logic [DMA_CHANNELS-1:0][2:0]  dump_fc;
  logic [DMA_CHANNELS-1:0][31:0] dump_ptr;
  logic [3:0]  cmd_q;
  logic        resp_valid, rwr_pend, rsp_pend, bd_empty, bus_address_error_flag_pending, dump_req, err_d;
  logic        mem_req, mem_we;
  logic [7:0]  mem_addr;
  logic [15:0] mem_wdata;

  wire        ack        = link.mem_ack;
  wire        idle       = state == ST_IDLE;
  wire        last3      = w == 2'h2;
  wire        take_dump  = idle && dump_req;
  wire        take_cmd   = idle && !dump_req && link.cmd_valid && (!severe_o || link.cmd_code == CMD_RESET);
  wire        go         = idle && !dump_req && !link.cmd_valid && !severe_o;
  wire        take_rwr   = go && rwr_pend;
  wire        take_rsp   = go && !rwr_pend && rsp_pend;
  wire        take_ev    = go && !rwr_pend && !rsp_pend && (pending != 16'h0);
  wire [15:0] new_bits   = pending & ~shadow;
  wire        is_reset   = take_cmd && link.cmd_code == CMD_RESET;
  wire        clr_done   = state == ST_CLR_WR && ack;
  wire        rsp_done   = state == ST_RSP_RD && ack && w == 2'h1;
  wire        rwr_done   = state == ST_RWR_WR && ack && w == 2'h1;
  wire        cmd_rd_end = state == ST_CMD_RD && ack && last3;
  wire        cc_ev      = state == ST_CMD_STS && ack && cmd_q != CMD_CLEAR_INT;
  wire        dump_done  = state == ST_DUMP && ack && ch == 2'h3 && last3;
  wire [1:0]  op         = cw[0][1:0];
  wire        skip_hit   = token_heard_i && ((token_sa_i > own_station_address_i && own_station_address_i > token_da_i)
                         || (token_da_i > token_sa_i && token_sa_i > own_station_address_i)
                         || (own_station_address_i > token_da_i && token_da_i > token_sa_i));
  wire        bus_err    = bus_error_code_inputs_i != 3'h0;
  wire        addr_err   = bus_master_i && (chip_select_i || iack_i);
  wire        err_hit    = dma_active_i && (bus_err || addr_err);
  wire        err_rise   = err_hit && !err_d;
  wire        underrun   = fifo_rd_i && fifo_empty_i;
  wire [7:0]  dump_base  = 8'(TBL_DUMP + 8'(ch * DUMP_STRIDE));

  // Event vector in status word 0 bit order, bit 15 first
  wire [15:0] ev_now = {cc_ev, fd_consumed_i && fd_last_i, bd_access_i && bd_last_i,
                        confirm_set_i && confirm_last_i, skip_hit, token_passed_i, dump_done,
                        fd_access_i && frame_pool_warning_bit_i, bd_access_i && buffer_pool_warning_bit_i,
                        fifo_wr_i && fifo_full_i, underrun, req_done_i, resp_done_i, misc_event_i};

  assign cmd_route = (link.cmd_code == CMD_RESET || link.cmd_code == CMD_LOAD_FC) ? ST_IDLE :
                     (link.cmd_code == CMD_CLEAR_INT) ? ST_CLR_WR :
                     (link.cmd_code == CMD_SET_ONE || link.cmd_code == CMD_SET_TWO ||
                      link.cmd_code == CMD_READ_VALUE) ? ST_CMD_RD : ST_CMD_STS;
  assign bd_grant_o       = bd_access_i && !bd_last_i;
  assign rx_header_only_o = bd_empty && fd_avail_i;
  assign link.cmd_ack     = take_cmd;
  assign link.irq         = (shadow & mask_q) != 16'h0;
  assign link.mem_req     = mem_req;
  assign link.mem_we      = mem_we;
  assign link.mem_addr    = mem_addr;
  assign link.mem_wdata   = mem_wdata;

  always_comb begin
    mem_req   = 1'b1;
    mem_we    = 1'b1;
    mem_addr  = 8'h00;
    mem_wdata = 16'h0000;
    unique case (state)
      ST_IDLE:    mem_req = 1'b0;
      ST_EV_RD:   begin mem_we = 1'b0; mem_addr = TBL_INT_STATUS0; end
      ST_EV_MK:   begin mem_we = 1'b0; mem_addr = TBL_INT_MASK0; end
      ST_EV_WR:   begin mem_addr = TBL_INT_STATUS0; mem_wdata = rd_word | snap; end
      ST_CLR_WR:  begin mem_addr = TBL_INT_STATUS0; mem_wdata = STATUS_RESET; end
      ST_CMD_RD:  begin mem_we = 1'b0; mem_addr = TBL_CMD_AREA + {5'h00, w, 1'b0}; end
      ST_CMD_RET: begin
        mem_addr  = TBL_RET_AREA + {5'h00, w, 1'b0};
        mem_wdata = (w == 2'h0) ? param[op][31:16] : (w == 2'h1) ? param[op][15:0] : cw[0];
      end
      ST_CMD_STS: begin mem_addr = TBL_CMD_STATUS; mem_wdata = DONE_MASK; end
      ST_RWR_WR:  begin
        mem_addr  = TBL_RWR_PTR + {5'h00, w, 1'b0};
        mem_wdata = w[0] ? rwr_addr[15:0] : rwr_addr[31:16];
      end
      ST_RSP_RD:  begin mem_we = 1'b0; mem_addr = TBL_RESP_PTR + {5'h00, w, 1'b0}; end
      ST_DUMP:    begin
        mem_addr  = dump_base + {5'h00, w, 1'b0};
        mem_wdata = (w == 2'h0) ? {13'h0000, dump_fc[ch]} :
                    (w == 2'h1) ? dump_ptr[ch][31:16] : dump_ptr[ch][15:0];
      end
      default:    mem_req = 1'b0;
    endcase
  end

  always_comb begin
    next_state = state;
    next_w     = w;
    next_ch    = ch;
    unique case (state)
      ST_IDLE: begin
        next_w  = 2'h0;
        next_ch = 2'h0;
        if (take_dump) next_state = ST_DUMP;
        else if (take_cmd) next_state = cmd_route;
        else if (take_rwr) next_state = ST_RWR_WR;
        else if (take_rsp) next_state = ST_RSP_RD;
        else if (take_ev && new_bits != 16'h0) next_state = ST_EV_RD;
      end
      ST_EV_RD:   if (ack) next_state = ST_EV_MK;
      ST_EV_MK:   if (ack) next_state = ST_EV_WR;
      ST_EV_WR:   if (ack) next_state = ST_IDLE;
      ST_CLR_WR:  if (ack) next_state = ST_CMD_STS;
      ST_CMD_STS: if (ack) next_state = ST_IDLE;
      ST_CMD_RD, ST_CMD_RET: if (ack) begin
        next_w = last3 ? 2'h0 : w + 2'h1;
        if (last3) next_state = (state == ST_CMD_RD && cmd_q == CMD_READ_VALUE) ? ST_CMD_RET : ST_CMD_STS;
      end
      ST_RWR_WR, ST_RSP_RD: if (ack) begin
        next_w = w + 2'h1;
        if (w == 2'h1) next_state = ST_IDLE;
      end
      ST_DUMP: if (ack) begin
        next_w = last3 ? 2'h0 : w + 2'h1;
        if (last3) next_ch = ch + 2'h1;
        if (dump_done) next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state <= ST_IDLE;
      w     <= 2'h0;
      ch    <= 2'h0;
    end else begin
      state <= next_state;
      w     <= next_w;
      ch    <= next_ch;
    end
  end

  // Mask copy moves with the status write so irq never changes on the mask read
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      shadow  <= 16'h0000;
      mask_q  <= 16'h0000;
      mask_rd <= 16'h0000;
      rd_word <= 16'h0000;
      pending <= 16'h0000;
      snap    <= 16'h0000;
    end else begin
      pending <= (take_ev ? 16'h0000 : pending) | ev_now;
      if (take_ev) snap <= new_bits;
      if (state == ST_EV_RD && ack) rd_word <= link.mem_rdata;
      if (state == ST_EV_MK && ack) mask_rd <= link.mem_rdata;
      if (state == ST_EV_WR && ack) mask_q <= mask_rd;
      if (clr_done) shadow <= STATUS_RESET;
      else if (state == ST_EV_WR && ack) shadow <= shadow | snap;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cmd_q            <= CMD_RESET;
      resp_valid       <= 1'b0;
      rwr_pend         <= 1'b0;
      rsp_pend         <= 1'b0;
      rwr_addr         <= 32'h0;
      rsp_hi           <= 16'h0000;
      reply_fd_valid_o <= 1'b0;
      reply_fd_addr_o  <= 32'h0;
      for (int i = 0; i < 3; i++) cw[i] <= 16'h0000;
      for (int i = 0; i < 4; i++) param[i] <= 32'h0;
    end else begin
      reply_fd_valid_o <= rsp_done;
      if (take_cmd) cmd_q <= link.cmd_code;
      if (state == ST_CMD_RD && ack) cw[w] <= link.mem_rdata;
      if (cmd_rd_end && cmd_q == CMD_SET_ONE) param[op] <= {16'h0000, cw[1]};
      if (cmd_rd_end && cmd_q == CMD_SET_TWO) param[op] <= {cw[1], link.mem_rdata};
      if (take_cmd && link.cmd_code == CMD_RESP_READY) resp_valid <= 1'b1;
      else if (rsp_done && !predefined_mode_i) resp_valid <= 1'b0;
      if (rwr_rx_i) rwr_addr <= rwr_fd_addr_i;
      if (rwr_rx_i) rwr_pend <= 1'b1;
      else if (rwr_done) rwr_pend <= 1'b0;
      if (rwr_rx_i && (predefined_mode_i || resp_valid)) rsp_pend <= 1'b1;
      else if (rsp_done) rsp_pend <= 1'b0;
      if (state == ST_RSP_RD && ack && w == 2'h0) rsp_hi <= link.mem_rdata;
      if (rsp_done) reply_fd_addr_o <= {rsp_hi, link.mem_rdata};
    end
  end

  // Bus/address error, severe state, pools and rotation timing
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      err_d            <= 1'b0;
      bus_address_error_flag_pending    <= 1'b0;
      severe_o         <= 1'b0;
      halt_o           <= 1'b0;
      dump_req         <= 1'b0;
      pass_token_o     <= 1'b0;
      seek_successor_o <= 1'b0;
      abort_o          <= 1'b0;
      bd_empty         <= 1'b0;
      rot_cnt          <= 32'h0;
      last_rotation_o  <= 32'h0;
      dump_fc          <= '0;
      dump_ptr         <= '0;
    end else begin
      err_d            <= err_hit;
      pass_token_o     <= 1'b0;
      seek_successor_o <= 1'b0;
      abort_o          <= underrun;
      if (take_dump) dump_req <= 1'b0;
      if (is_reset) begin
        severe_o      <= 1'b0;
        bus_address_error_flag_pending <= 1'b0;
        halt_o        <= 1'b0;
      end else if (err_rise && !severe_o) begin
        if (bus_address_error_flag_pending || offline_i) severe_o <= 1'b1;
        else begin
          bus_address_error_flag_pending    <= 1'b1;
          halt_o           <= 1'b1;
          dump_req         <= 1'b1;
          dump_fc          <= dma_fc_i;
          dump_ptr         <= dma_ptr_i;
          pass_token_o     <= has_token_i && has_successor_i;
          seek_successor_o <= has_token_i && !has_successor_i;
        end
      end else if (clr_done) begin
        bus_address_error_flag_pending <= 1'b0;
        halt_o        <= 1'b0;
      end
      if (bd_access_i && bd_last_i) bd_empty <= 1'b1;
      else if (bd_refill_i) bd_empty <= 1'b0;
      if (token_passed_i) begin
        last_rotation_o <= rot_cnt;
        rot_cnt         <= 32'h0;
      end else rot_cnt <= rot_cnt + 32'h1;
    end
  end
endmodule
`default_nettype wire

// File: verilog/tbs_host.sv
// Host end: shared table memory, APB register access and command issue
`timescale 1ns/1ps
`default_nettype none
module tbs_host
  import tbs_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  tbs_link_if.host         link
);
  logic [15:0] tbl [TBL_WORDS];
  logic        ack_q, cmd_valid_q, set2_done;
  logic [15:0] rdata_q;
  logic [3:0]  code_q;

  wire       dev_slot    = link.mem_req && !ack_q;
  wire       tbl_sel     = paddr_i <= APB_TABLE_LAST;
  wire       cmd_sel     = paddr_i == APB_CMD;
  wire       stat_sel    = paddr_i == APB_STAT;
  wire       access      = psel_i && penable_i;
  wire [6:0] apb_idx     = paddr_i[8:2];
  wire [6:0] dev_idx     = link.mem_addr[7:1];
  wire       bus_address_error_flag_seen  = tbl[TBL_INT_STATUS0[7:1]][BIT_BUS_ADDRESS_ERROR_FLAG];
  wire       done_bit    = tbl[TBL_CMD_STATUS[7:1]][BIT_DONE];
  // Clearing a bus error is refused until fresh pools were handed over
  wire       clr_blocked = pwdata_i[3:0] == CMD_CLEAR_INT && bus_address_error_flag_seen && !set2_done;
  wire       refused     = cmd_valid_q || clr_blocked;
  wire       issue       = access && pwrite_i && cmd_sel && !refused;
  wire       tbl_wr      = access && pready_o && pwrite_i && tbl_sel;

  assign pready_o  = !(tbl_sel && dev_slot);
  assign pslverr_o = access && pready_o && (!(tbl_sel || cmd_sel || stat_sel) ||
                     (cmd_sel && pwrite_i && refused) || (stat_sel && pwrite_i));
  assign prdata_o  = tbl_sel  ? {16'h0000, tbl[apb_idx]} :
                     stat_sel ? {29'h0, done_bit, link.irq, cmd_valid_q} : 32'h0;
  assign link.mem_ack   = ack_q;
  assign link.mem_rdata = rdata_q;
  assign link.cmd_valid = cmd_valid_q;
  assign link.cmd_code  = code_q;

  // Device write comes last so it wins over the done clear on the same word
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < TBL_WORDS; i++) tbl[i] <= STATUS_RESET;
    end else begin
      if (tbl_wr) tbl[apb_idx] <= pwdata_i[15:0];
      if (issue) tbl[TBL_CMD_STATUS[7:1]] <= tbl[TBL_CMD_STATUS[7:1]] & ~DONE_MASK;
      if (dev_slot && link.mem_we) tbl[dev_idx] <= link.mem_wdata;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ack_q       <= 1'b0;
      rdata_q     <= 16'h0000;
      cmd_valid_q <= 1'b0;
      code_q      <= CMD_RESET;
      set2_done   <= 1'b0;
    end else begin
      ack_q   <= dev_slot;
      rdata_q <= tbl[dev_idx];
      if (issue) begin
        cmd_valid_q <= 1'b1;
        code_q      <= pwdata_i[3:0];
      end else if (link.cmd_ack) cmd_valid_q <= 1'b0;
      if (issue && pwdata_i[3:0] == CMD_SET_TWO) set2_done <= 1'b1;
      else if (issue && pwdata_i[3:0] == CMD_CLEAR_INT) set2_done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: dv/tbs_link_chk.sv
// Link assertions checker
`timescale 1ns/1ps
`default_nettype none
module tbs_link_chk
  import tbs_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        resetn_i,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [7:0]  mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic        mem_ack,
  input wire logic [3:0]  cmd_code,
  input wire logic        cmd_ack,
  input wire logic        irq
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // Cycles since last clear-interrupt or reset command
  logic [4:0] since_clr;
  wire logic  clr_cmd = cmd_ack && (cmd_code == CMD_CLEAR_INT || cmd_code == CMD_RESET);
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i || clr_cmd) since_clr <= 5'h00;
    else if (since_clr != 5'h1f) since_clr <= since_clr + 5'h01;
  end
  sequence s_stat_wr;
    mem_req && mem_we && mem_addr == TBL_INT_STATUS0;
  endsequence
  sequence s_done_wr;
    mem_req && mem_we && mem_addr == TBL_CMD_STATUS && mem_wdata == DONE_MASK;
  endsequence
  property p_ack_once; mem_req && !mem_ack |=> mem_ack ##1 !mem_ack; endproperty
  property p_req_hold; mem_req && !mem_ack |=> $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata); endproperty
  property p_rmw; s_stat_wr ##0 (!mem_ack && mem_wdata != 16'h0000)
    |-> $past(mem_req && !mem_we && mem_addr == TBL_INT_STATUS0, 4); endproperty
  property p_irq_rise; $rose(irq) |-> $past(mem_ack && mem_we && mem_addr == TBL_INT_STATUS0); endproperty
  property p_irq_fall; $fell(irq) |-> since_clr < 5'h10; endproperty
  property p_clear_wr; cmd_ack && cmd_code == CMD_CLEAR_INT |-> ##[0:8] s_stat_wr ##0 mem_wdata == 16'h0000; endproperty
  property p_done; cmd_ack && cmd_code > CMD_LOAD_FC |-> ##[0:40] s_done_wr; endproperty
  property p_no_done; cmd_ack && cmd_code <= CMD_LOAD_FC
    |=> !(mem_req && mem_we && mem_addr == TBL_CMD_STATUS) [*8]; endproperty
  a_ack_once: assert property (p_ack_once) else $error("no ack");
  a_req_hold: assert property (p_req_hold) else $error("req moved");
  a_rmw: assert property (p_rmw) else $error("no status read");
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose");
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell");
  a_clear_wr: assert property (p_clear_wr) else $error("no clear write");
  a_done: assert property (p_done) else $error("no done");
  a_no_done: assert property (p_no_done) else $error("stray done");
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Bench: APB and event pins against a status model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tbs_pkg::*;
  logic clk_sys_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, e, pready_o, pslverr_o;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, rwr_fd_addr_i = 0, prdata_o, reply_fd_addr_o, last_rotation_o, r, a = 0, b, rep;
  logic bd_grant_o, rx_header_only_o, abort_o, halt_o, pass_token_o, seek_successor_o, severe_o, reply_fd_valid_o;
  logic predefined_mode_i = 0, rwr_rx_i = 0, fd_consumed_i = 0, fd_last_i = 0, fd_access_i = 0, fd_avail_i = 0;
  logic frame_pool_warning_bit_i = 0, bd_access_i = 0, bd_last_i = 0, buffer_pool_warning_bit_i = 0, bd_refill_i = 0;
  logic confirm_set_i = 0, confirm_last_i = 0, token_heard_i = 0, token_passed_i = 0, dma_active_i = 0, iack_i = 0;
  logic bus_master_i = 0, chip_select_i = 0, has_token_i = 0, has_successor_i = 0, offline_i = 0, fifo_wr_i = 0;
  logic fifo_full_i = 0, fifo_rd_i = 0, fifo_empty_i = 0, req_done_i = 0, resp_done_i = 0;
  logic [15:0] token_sa_i = 0, token_da_i = 0, own_station_address_i = 0;
  logic [2:0] bus_error_code_inputs_i = 0, misc_event_i = 0;
  logic [DMA_CHANNELS-1:0][2:0] dma_fc_i = 0;
  logic [DMA_CHANNELS-1:0][31:0] dma_ptr_i = 0;
  int n_fail = 0, tests_run = 0, seed = 77, st = 0, iq = 0, nrep = 0, w, k;
  tbs_link_if link();
  tbs_device i_tbs_device (.*);
  tbs_host i_tbs_host (.*);
  tbs_link_chk i_tbs_link_chk (.clk_sys_i, .resetn_i, .mem_req(link.mem_req), .mem_we(link.mem_we),
    .mem_addr(link.mem_addr), .mem_wdata(link.mem_wdata), .mem_ack(link.mem_ack), .cmd_code(link.cmd_code),
    .cmd_ack(link.cmd_ack), .irq(link.irq));
  always #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (reply_fd_valid_o === 1'b1) begin
    nrep <= nrep + 1;
    rep <= reply_fd_addr_o;
  end
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task stop_test;
    $display("%0d checks, %0d fails", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One APB transfer
  task apb(logic wr, logic [11:0] ad, logic [31:0] d);
    psel_i <= 1; pwrite_i <= wr; paddr_i <= ad; pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    e = pslverr_o;
    r = prdata_o;
    psel_i <= 0; penable_i <= 0;
    @(posedge clk_sys_i);
  endtask
  task tw(logic [7:0] off, logic [31:0] exp);
    for (k = 0; k < 40; k++) begin
      apb(0, {3'h0, off, 1'b0}, 0);
      if (r === exp) break;
    end
    chk($sformatf("table %h", off), r, exp);
  endtask
  task cmd(logic [3:0] c);
    apb(1, APB_CMD, {28'h0, c});
    for (k = 0; k < 40; k++) begin
      apb(0, APB_STAT, 0);
      if (r[STAT_BUSY] === 1'b0) break;
    end
  endtask
  task par(logic [3:0] c, logic [31:0] op, logic [31:0] v1, logic [31:0] v2);
    apb(1, 12'h120, op); apb(1, 12'h124, v1); apb(1, 12'h128, v2);
    cmd(c);
    tw(TBL_CMD_STATUS, {16'h0, DONE_MASK});
  endtask
  task request_with_reply_frame(int want);
    a = $random(seed);
    rwr_fd_addr_i <= a; rwr_rx_i <= 1;
    @(posedge clk_sys_i);
    rwr_rx_i <= 0;
    tw(TBL_RWR_PTR, {16'h0, a[31:16]});
    tw(8'h8e, {16'h0, a[15:0]});
    for (k = 0; k < 30 && nrep != want; k++) @(posedge clk_sys_i);
    chk("replies", nrep, want);
  endtask
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    n_fail++;
    stop_test;
  end
  initial begin
    repeat (4) @(posedge clk_sys_i);
    resetn_i <= 1;
    @(posedge clk_sys_i);
    apb(0, 12'h300, 0);
    chk("pslverr", {31'h0, e}, 1);
    for (w = 0; w < 6; w++) begin
      a = a | ($random(seed) & 32'hffff);
      b = $random(seed) & 32'h3f;
      apb(1, 12'h154, a);
      {token_passed_i, req_done_i, resp_done_i, misc_event_i} <= b[5:0];
      @(posedge clk_sys_i);
      {token_passed_i, req_done_i, resp_done_i, misc_event_i} <= 6'h00;
      r = {21'h0, b[5], 5'h00, b[4:0]};
      if ((st | r) != st) iq = |((st | r) & a);
      st = st | r;
      tw(TBL_INT_STATUS0, st);
      apb(0, APB_STAT, 0);
      chk("irq", {31'h0, r[STAT_IRQ]}, iq);
    end
    $display("events done");
    a = $random(seed) & 32'hffff;
    b = $random(seed) & 32'hffff;
    par(CMD_SET_TWO, 1, a, b);
    par(CMD_SET_ONE, 2, b, a);
    par(CMD_READ_VALUE, 1, 0, 0);
    tw(8'h96, a); tw(8'h98, b); tw(8'h9a, 1);
    par(CMD_READ_VALUE, 2, 0, 0);
    tw(8'h96, 0); tw(8'h98, b);
    st = st | 32'h8000;
    tw(TBL_INT_STATUS0, st);
    cmd(CMD_CLEAR_INT);
    tw(TBL_CMD_STATUS, {16'h0, DONE_MASK});
    tw(TBL_INT_STATUS0, 0);
    apb(0, APB_STAT, 0);
    chk("irq clr", {31'h0, r[STAT_IRQ]}, 0);
    $display("commands done");
    request_with_reply_frame(0);
    b = $random(seed);
    apb(1, 12'h110, {16'h0, b[31:16]}); apb(1, 12'h114, {16'h0, b[15:0]});
    cmd(CMD_RESP_READY);
    request_with_reply_frame(1);
    chk("reply", rep, b);
    request_with_reply_frame(1);
    predefined_mode_i <= 1;
    request_with_reply_frame(2);
    chk("predef", rep, b);
    $display("replies done");
    dma_ptr_i <= {$random(seed), $random(seed), $random(seed), $random(seed)};
    dma_fc_i <= 12'($random(seed));
    has_token_i <= 1; dma_active_i <= 1; bus_error_code_inputs_i <= 3'h2;
    @(posedge clk_sys_i);
    dma_active_i <= 0; bus_error_code_inputs_i <= 3'h0;
    for (w = 0; w < 4; w++) begin
      tw(8'he0 + 8'(6 * w), {29'h0, dma_fc_i[w]});
      tw(8'he2 + 8'(6 * w), {16'h0, dma_ptr_i[w][31:16]});
      tw(8'he4 + 8'(6 * w), {16'h0, dma_ptr_i[w][15:0]});
    end
    tw(TBL_INT_STATUS0, 32'h8200);
    chk("halt", {31'h0, halt_o}, 1);
    bus_master_i <= 1; chip_select_i <= 1; dma_active_i <= 1;
    @(posedge clk_sys_i);
    dma_active_i <= 0;
    for (k = 0; k < 10 && severe_o !== 1'b1; k++) @(posedge clk_sys_i);
    chk("severe", {31'h0, severe_o}, 1);
    cmd(CMD_RESET);
    tw(TBL_CMD_STATUS, 0);
    chk("severe left", {31'h0, severe_o}, 0);
    cmd(CMD_LOAD_FC);
    tw(TBL_CMD_STATUS, 0);
    $display("bus error done");
    stop_test;
  end
endmodule
`default_nettype wire
